// ===== design/dos_pkg.sv
// Constants, field layouts and state codes for the DC offset servo registers.
// Assumes a 250 MHz clock and word-aligned AHB-Lite register access.
package dos_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned NCH    = 4;
  localparam int unsigned CODE_W = 8;
  localparam int unsigned STAT_W = 12;

  // ---------------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_TRIGGER = 8'h44;
  localparam logic [7:0] IDX_LINE_R  = 8'h49;
  localparam logic [7:0] IDX_LINE_L  = 8'h4a;
  localparam logic [7:0] IDX_PHONE_R = 8'h4b;
  localparam logic [7:0] IDX_PHONE_L = 8'h4c;
  localparam logic [7:0] IDX_STATUS  = 8'h4d;
  localparam logic [7:0] IDX_NONE    = 8'h00;

  // ---------------------------------------------------------------------------
  // Channel numbers, equal to their bit position in status and trigger fields
  // ---------------------------------------------------------------------------
  localparam int unsigned CH_PHONE_L = 0;
  localparam int unsigned CH_PHONE_R = 1;
  localparam int unsigned CH_LINE_L  = 2;
  localparam int unsigned CH_LINE_R  = 3;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned STAT_ANY_LSB   = 8;
  localparam int unsigned STAT_VAL_LSB   = 4;
  localparam int unsigned STAT_START_LSB = 0;
  localparam int unsigned TRIG_VAL_LSB   = 0;
  localparam int unsigned TRIG_START_LSB = 4;
  localparam logic [7:0]  RST_OFFSET     = 8'h00;
  localparam logic [11:0] RST_STATUS     = 12'h000;
  localparam logic [7:0]  CODE_MAX       = 8'h7f;
  localparam logic [7:0]  CODE_MIN       = 8'h80;

  // ---------------------------------------------------------------------------
  // Analogue scale of one code step, in microvolts
  // ---------------------------------------------------------------------------
  localparam int unsigned LSB_UV  = 250;
  localparam int unsigned SPAN_UV = 32000;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_NS    = 4;
  localparam int unsigned STEP_NS   = 1000;
  localparam int unsigned STEP_CYC  = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  STEP_LAST = 8'(STEP_CYC - 1);

  // ---------------------------------------------------------------------------
  // AHB-Lite codes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'b010;

  typedef enum logic [1:0] {
    DOS_IDLE      = 2'b00,
    DOS_RUN_VAL   = 2'b01,
    DOS_RUN_START = 2'b10
  } dos_state_t;

  function automatic logic [7:0] dos_off_idx(input int unsigned ch);
    return IDX_PHONE_L - 8'(ch);
  endfunction

endpackage

// ===== design/dos_ahb.sv
// AHB-Lite slave front end: writes with no wait state, reads with one.
// Assumes a single slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
`default_nettype none
module dos_ahb
  import dos_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic [31:0] rd_word_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  output logic             wr_en_o,
  output logic             rd_en_o,
  output logic [7:0]       idx_o,
  output logic [31:0]      wr_data_o
);

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  idx;
    logic [31:0] rdata;
    logic        ready;
    logic        resp;
  } dos_ahb_t;

  dos_ahb_t q;
  dos_ahb_t d;
  logic     taken;
  logic     mapped;

  // ---------------------------------------------------------------------------
  // Address and data phase
  // ---------------------------------------------------------------------------
  always_comb begin
    taken  = hsel_i && htrans_i[1] && hready_i;
    mapped = (haddr_i[31:10] == 22'h000000) && (haddr_i[1:0] == 2'b00) && (hsize_i == HSIZE_WORD);
    d      = q;
    d.wr   = taken && hwrite_i;
    d.rd   = taken && !hwrite_i;
    if (taken) begin
      d.idx = mapped ? haddr_i[9:2] : IDX_NONE;
    end
    // Read data is sampled a cycle late so a write just before is seen
    d.ready = !(taken && !hwrite_i);
    if (q.rd) begin
      d.rdata = rd_word_i;
      d.ready = 1'b1;
    end
    d.resp = 1'b0;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{wr: 1'b0, rd: 1'b0, idx: 8'h00, rdata: 32'h00000000, ready: 1'b1, resp: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign hreadyout_o = q.ready;
  assign hresp_o     = q.resp;
  assign hrdata_o    = q.rdata;
  assign wr_en_o     = q.wr;
  assign rd_en_o     = q.rd;
  assign idx_o       = q.idx;
  assign wr_data_o   = hwdata_i;

endmodule
`default_nettype wire

// ===== design/dos_chan.sv
// One output's correction engine: ramps the applied code one step per tick.
// Assumes tick_i is a one-cycle enable and triggers are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module dos_chan
  import dos_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       tick_i,
  input  wire logic       value_trig_i,
  input  wire logic       start_trig_i,
  input  wire logic [7:0] tgt_i,
  input  wire logic [7:0] sense_i,
  output logic [7:0]      applied_o,
  output logic            val_busy_o,
  output logic            start_busy_o,
  output logic            val_done_o,
  output logic            start_done_o
);

  typedef struct packed {
    dos_state_t st;
    logic [7:0] applied;
    logic [7:0] aim;
    logic       val_done;
    logic       start_done;
  } dos_chan_t;

  dos_chan_t  q;
  dos_chan_t  d;
  logic [7:0] aim;

  // ---------------------------------------------------------------------------
  // Correction sequence
  // ---------------------------------------------------------------------------
  always_comb begin
    d   = q;
    aim = (q.st == DOS_RUN_VAL) ? tgt_i : q.aim;
    case (q.st)
      DOS_IDLE: begin
        // Triggers while busy are ignored, so done bits never see set and clear together
        if (value_trig_i) begin
          d.st       = DOS_RUN_VAL;
          d.val_done = 1'b0;
        end else if (start_trig_i) begin
          d.st         = DOS_RUN_START;
          d.start_done = 1'b0;
          d.aim        = (sense_i == CODE_MIN) ? CODE_MAX : 8'(-sense_i);
        end
      end
      DOS_RUN_VAL, DOS_RUN_START: begin
        if (tick_i) begin
          if (q.applied == aim) begin
            d.st = DOS_IDLE;
            if (q.st == DOS_RUN_VAL) begin
              d.val_done = 1'b1;
            end else begin
              d.start_done = 1'b1;
            end
          end else if ($signed(q.applied) < $signed(aim)) begin
            d.applied = q.applied + 8'h01;
          end else begin
            d.applied = q.applied - 8'h01;
          end
        end
      end
      default: begin
        d.st = DOS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{st: DOS_IDLE, applied: RST_OFFSET, aim: RST_OFFSET, val_done: 1'b0, start_done: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign applied_o    = q.applied;
  assign val_busy_o   = (q.st == DOS_RUN_VAL);
  assign start_busy_o = (q.st == DOS_RUN_START);
  assign val_done_o   = q.val_done;
  assign start_done_o = q.start_done;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  chk_step_size: assert property ($changed(q.applied) |-> $past(tick_i) &&
    (q.applied == $past(q.applied) + 8'h01 || q.applied == $past(q.applied) - 8'h01))
    else $error("applied code moved by more than one step");
  chk_val_done: assert property ($rose(q.val_done) |-> q.applied == $past(tgt_i) &&
    $past(q.st) == DOS_RUN_VAL && q.st == DOS_IDLE)
    else $error("value done without reaching target");
  chk_start_done: assert property ($rose(q.start_done) |-> $past(q.st) == DOS_RUN_START)
    else $error("start-up done outside start-up run");
  chk_val_start: assert property (q.st == DOS_IDLE && value_trig_i |=> val_busy_o && !val_done_o)
    else $error("value trigger did not start a correction");

endmodule
`default_nettype wire

// ===== design/dos_servo_regs.sv
// Register bank of the output DC offset servo, reached over AHB-Lite.
// Assumes the analogue servo reads applied_code_o and supplies sense_code_i.
//
// Overview of operation
// - Four 8-bit signed offset registers at 49h to 4Ch: line R, line L, phone R, phone L.
// - Reading an offset register returns the offset currently applied, possibly not the written one.
// - One code step is 0.25 mV, so the code spans about plus or minus 32 mV.
// - Status bits 11:8 show per output that either correction completed.
// - Status bits 7:4 show per output that write-value correction completed.
// - Status bits 3:0 show per output that start-up correction completed.
// - Writing 1 to an idle output's trigger bit starts write-value correction toward its register.
// - Trigger bit reads 1 while that output's write-value correction runs.
`timescale 1ns/1ps
`default_nettype none
module dos_servo_regs
  import dos_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          resetn_i,
  input  wire logic                          hsel_i,
  input  wire logic [31:0]                   haddr_i,
  input  wire logic [1:0]                    htrans_i,
  input  wire logic                          hwrite_i,
  input  wire logic [2:0]                    hsize_i,
  input  wire logic                          hready_i,
  input  wire logic [31:0]                   hwdata_i,
  input  wire logic [NCH-1:0][CODE_W-1:0]    sense_code_i,
  output logic                               hreadyout_o,
  output logic                               hresp_o,
  output logic [31:0]                        hrdata_o,
  output logic [NCH-1:0][CODE_W-1:0]         applied_code_o
);

  typedef struct packed {
    logic [NCH-1:0][CODE_W-1:0] tgt;
    logic [7:0]                 div;
    logic                       tick;
    logic [NCH-1:0]             trig_val;
    logic [NCH-1:0]             trig_start;
  } dos_top_t;

  dos_top_t                   q;
  dos_top_t                   d;
  logic                       wr_en;
  logic                       rd_en;
  logic [7:0]                 idx;
  logic [31:0]                wr_data;
  logic [31:0]                rd_word;
  logic [NCH-1:0]             val_busy;
  logic [NCH-1:0]             start_busy;
  logic [NCH-1:0]             val_done;
  logic [NCH-1:0]             start_done;
  logic [STAT_W-1:0]          status;

  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------
  dos_ahb u_ahb (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hready_i    (hready_i),
    .hwdata_i    (hwdata_i),
    .rd_word_i   (rd_word),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .hrdata_o    (hrdata_o),
    .wr_en_o     (wr_en),
    .rd_en_o     (rd_en),
    .idx_o       (idx),
    .wr_data_o   (wr_data)
  );

  // ---------------------------------------------------------------------------
  // Correction engines, one per output
  // ---------------------------------------------------------------------------
  for (genvar k = 0; k < NCH; k++) begin : g_chan
    dos_chan u_chan (
      .clk_i        (clk_i),
      .resetn_i     (resetn_i),
      .tick_i       (q.tick),
      .value_trig_i (q.trig_val[k]),
      .start_trig_i (q.trig_start[k]),
      .tgt_i        (q.tgt[k]),
      .sense_i      (sense_code_i[k]),
      .applied_o    (applied_code_o[k]),
      .val_busy_o   (val_busy[k]),
      .start_busy_o (start_busy[k]),
      .val_done_o   (val_done[k]),
      .start_done_o (start_done[k])
    );
  end

  // ---------------------------------------------------------------------------
  // Status word, derived only from engine state so no write can reach it
  // ---------------------------------------------------------------------------
  always_comb begin
    status = RST_STATUS;
    status[STAT_ANY_LSB +: NCH]   = val_done | start_done;
    status[STAT_VAL_LSB +: NCH]   = val_done;
    status[STAT_START_LSB +: NCH] = start_done;
  end

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_word = 32'h00000000;
    for (int unsigned k = 0; k < NCH; k++) begin
      if (idx == dos_off_idx(k)) begin
        rd_word[CODE_W-1:0] = applied_code_o[k];
      end
    end
    if (idx == IDX_TRIGGER) begin
      rd_word[TRIG_VAL_LSB +: NCH]   = val_busy;
      rd_word[TRIG_START_LSB +: NCH] = start_busy;
    end
    if (idx == IDX_STATUS) begin
      rd_word[STAT_W-1:0] = status;
    end
  end

  // ---------------------------------------------------------------------------
  // Writes, trigger pulses and step divider
  // ---------------------------------------------------------------------------
  always_comb begin
    d            = q;
    d.trig_val   = '0;
    d.trig_start = '0;
    d.tick       = (q.div == STEP_LAST);
    d.div        = d.tick ? 8'h00 : q.div + 8'h01;
    if (wr_en) begin
      for (int unsigned k = 0; k < NCH; k++) begin
        if (idx == dos_off_idx(k)) begin
          d.tgt[k] = wr_data[CODE_W-1:0];
        end
      end
      if (idx == IDX_TRIGGER) begin
        d.trig_val   = wr_data[TRIG_VAL_LSB +: NCH];
        d.trig_start = wr_data[TRIG_START_LSB +: NCH];
      end
      // A write to the status index falls through untouched
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{tgt: {NCH{RST_OFFSET}}, div: 8'h00, tick: 1'b0, trig_val: 4'h0, trig_start: 4'h0};
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_rd_line_r;
    rd_en && idx == IDX_LINE_R;
  endsequence
  sequence s_rd_trig;
    rd_en && idx == IDX_TRIGGER;
  endsequence
  sequence s_rd_stat;
    rd_en && idx == IDX_STATUS;
  endsequence
  sequence s_wr_off;
    wr_en && idx == IDX_PHONE_L;
  endsequence

  chk_offset_write: assert property (s_wr_off |=> q.tgt[CH_PHONE_L] == $past(wr_data[7:0]))
    else $error("offset write not stored");
  chk_offset_read: assert property (s_rd_line_r |=> hrdata_o == {24'h000000, $past(applied_code_o[CH_LINE_R])})
    else $error("offset read is not the applied code");
  chk_busy_read: assert property (s_rd_trig |=> hrdata_o[3:0] == $past(val_busy) && hreadyout_o)
    else $error("trigger readback differs from busy");
  chk_any_read: assert property (s_rd_stat |=> hrdata_o[11:8] == ($past(val_done) | $past(start_done)))
    else $error("combined done bits wrong");
  chk_val_read: assert property (s_rd_stat |=> hrdata_o[7:4] == $past(val_done) && hrdata_o[31:12] == 20'h00000)
    else $error("value done bits wrong");
  chk_start_read: assert property (s_rd_stat |=> hrdata_o[3:0] == $past(start_done))
    else $error("start-up done bits wrong");
  chk_trig_start: assert property (wr_en && idx == IDX_TRIGGER && wr_data[0] && !val_busy[0] && !start_busy[0]
    |-> ##2 val_busy[0])
    else $error("trigger write did not start correction");
  chk_status_ro: assert property (wr_en && idx == IDX_STATUS |=> $stable(q.tgt) && q.trig_val == 4'h0)
    else $error("status write had an effect");
  chk_tick_gap: assert property (q.tick |=> !q.tick [*8])
    else $error("step enable too frequent");

  // ---------------------------------------------------------------------------
  // Per-output checks, one set for each engine
  // ---------------------------------------------------------------------------
  // Clock and reset are named here so the checks do not lean on scope rules
  for (genvar k = 0; k < NCH; k++) begin : g_chk
    sequence s_wr_code;
      wr_en && idx == dos_off_idx(k);
    endsequence
    sequence s_rd_code;
      rd_en && idx == dos_off_idx(k);
    endsequence
    sequence s_wr_trig;
      wr_en && idx == IDX_TRIGGER && wr_data[TRIG_VAL_LSB + k];
    endsequence

    chk_code_store: assert property (@(posedge clk_i) disable iff (!resetn_i)
      s_wr_code |=> q.tgt[k] == $past(wr_data[CODE_W-1:0]))
      else $error("offset target not stored");
    chk_code_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
      s_rd_code |=> hrdata_o[CODE_W-1:0] == $past(applied_code_o[k]) && hrdata_o[31:CODE_W] == 24'h000000)
      else $error("offset readback is not the applied code");
    chk_trig_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
      s_wr_trig |=> q.trig_val[k])
      else $error("trigger write gave no start pulse");
    chk_busy_bit: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rd_en && idx == IDX_TRIGGER |=> hrdata_o[TRIG_VAL_LSB + k] == $past(val_busy[k]))
      else $error("trigger bit readback differs from busy");
    // Done bits are sticky: only a fresh start of the same mode may clear them
    chk_val_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
      val_done[k] && !q.trig_val[k] |=> val_done[k])
      else $error("value done bit dropped without a restart");
    chk_start_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_done[k] && !q.trig_start[k] |=> start_done[k])
      else $error("start-up done bit dropped without a restart");
  end

endmodule
`default_nettype wire

// ===== tb/test_dos_servo_regs.sv
// Self-checking testbench for the DC offset servo register bank.
// Assumes the bench is the only AHB-Lite master and hreadyout feeds hready.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("[FAIL] %0t mismatch got %h expected %h", $time, (got), (exp)); \
    end \
  end

module test_dos_servo_regs;
  import dos_pkg::*;

  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic                       clk_i;
  logic                       resetn_i;
  logic                       hsel_i;
  logic [31:0]                haddr_i;
  logic [1:0]                 htrans_i;
  logic                       hwrite_i;
  logic [2:0]                 hsize_i;
  wire logic                  hready_i;
  logic [31:0]                hwdata_i;
  logic [NCH-1:0][CODE_W-1:0] sense_code_i;
  logic                       hreadyout_o;
  logic                       hresp_o;
  logic [31:0]                hrdata_o;
  logic [NCH-1:0][CODE_W-1:0] applied_code_o;
  int                         error_cnt;
  int                         samples_checked;
  logic [31:0]                rd;

  assign hready_i = hreadyout_o;

  dos_servo_regs i_dut (
    .clk_i          (clk_i),
    .resetn_i       (resetn_i),
    .hsel_i         (hsel_i),
    .haddr_i        (haddr_i),
    .htrans_i       (htrans_i),
    .hwrite_i       (hwrite_i),
    .hsize_i        (hsize_i),
    .hready_i       (hready_i),
    .hwdata_i       (hwdata_i),
    .sense_code_i   (sense_code_i),
    .hreadyout_o    (hreadyout_o),
    .hresp_o        (hresp_o),
    .hrdata_o       (hrdata_o),
    .applied_code_o (applied_code_o)
  );

  // ---------------------------------------------------------------------------
  // Clock, reset values and watchdog
  // ---------------------------------------------------------------------------
  initial clk_i = 1'b0;
  always #2 clk_i = ~clk_i;

  initial begin
    resetn_i        = 1'b0;
    hsel_i          = 1'b0;
    haddr_i         = 32'h0000_0000;
    htrans_i        = 2'b00;
    hwrite_i        = 1'b0;
    hsize_i         = HSIZE_WORD;
    hwdata_i        = 32'h0000_0000;
    sense_code_i    = '0;
    error_cnt       = 0;
    samples_checked = 0;
  end

  // Ramps are a few microseconds each; the limit leaves ample margin
  initial begin
    repeat (40000) @(posedge clk_i);
    error_cnt++;
    stop_test();
  end

  // ---------------------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------------------
  // hready is a flop, so its value at the falling edge is the one the next
  // rising edge samples; this avoids racing the design's own update.
  task automatic wait_rdy(output logic [31:0] data);
    logic r;
    do begin
      @(negedge clk_i);
      r    = hreadyout_o;
      data = hrdata_o;
      @(posedge clk_i);
    end while (r !== 1'b1);
  endtask

  task automatic ahb_xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                          output logic [31:0] data);
    logic [31:0] dummy;
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i  <= {22'h000000, idx, 2'b00};
    hwrite_i <= wr;
    hsize_i  <= HSIZE_WORD;
    wait_rdy(dummy);
    htrans_i <= 2'b00;
    hsel_i   <= 1'b0;
    hwdata_i <= wr ? wd : 32'h0000_0000;
    wait_rdy(data);
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] dummy;
    ahb_xfer(idx, 1'b1, wd, dummy);
  endtask

  task automatic reg_rd(input logic [7:0] idx, output logic [31:0] data);
    ahb_xfer(idx, 1'b0, 32'h0000_0000, data);
    `CHK(hresp_o, 1'b0)
  endtask

  // Polls the trigger register until the masked busy bits clear
  task automatic wait_idle(input logic [7:0] mask);
    logic [31:0] t;
    int          n;
    n = 0;
    do begin
      repeat (50) @(posedge clk_i);
      reg_rd(IDX_TRIGGER, t);
      n++;
    end while (((t[7:0] & mask) !== 8'h00) && (n < 200));
    `CHK(t[7:0] & mask, 8'h00)
  endtask

  task automatic stop_test();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;

    // Reset values of the whole map, unmapped index reads zero
    reg_rd(IDX_LINE_R, rd);   `CHK(rd, 32'h0000_0000)
    reg_rd(IDX_LINE_L, rd);   `CHK(rd, 32'h0000_0000)
    reg_rd(IDX_PHONE_R, rd);  `CHK(rd, 32'h0000_0000)
    reg_rd(IDX_PHONE_L, rd);  `CHK(rd, 32'h0000_0000)
    reg_rd(IDX_STATUS, rd);   `CHK(rd, {20'h00000, RST_STATUS})
    reg_rd(IDX_TRIGGER, rd);  `CHK(rd, 32'h0000_0000)
    reg_wr(IDX_NONE, 32'h0000_00a5);
    reg_rd(IDX_NONE, rd);     `CHK(rd, 32'h0000_0000)

    // Targets written but not applied: readback shows the applied code
    reg_wr(IDX_PHONE_L, 32'h0000_0003);
    reg_wr(IDX_LINE_R, 32'h0000_00fe);
    reg_rd(IDX_PHONE_L, rd);  `CHK(rd, 32'h0000_0000)
    reg_rd(IDX_LINE_R, rd);   `CHK(rd, 32'h0000_0000)

    // Value correction on two outputs at once, busy while running
    reg_wr(IDX_TRIGGER, 32'h0000_0009);
    reg_rd(IDX_TRIGGER, rd);  `CHK(rd[3:0], 4'h9)
    reg_rd(IDX_STATUS, rd);   `CHK(rd[11:0], 12'h000)
    wait_idle(8'h0f);
    reg_rd(IDX_PHONE_L, rd);  `CHK(rd, 32'h0000_0003)
    reg_rd(IDX_LINE_R, rd);   `CHK(rd, 32'h0000_00fe)
    `CHK(applied_code_o[CH_PHONE_L], 8'h03)
    `CHK(applied_code_o[CH_LINE_R], 8'hfe)
    `CHK(applied_code_o[CH_LINE_L], 8'h00)
    // Code scale: -2 steps is -500 uV
    `CHK($signed(applied_code_o[CH_LINE_R]) * $signed(LSB_UV), -500)
    reg_rd(IDX_STATUS, rd);   `CHK(rd[11:0], 12'h990)

    // Start-up correction on phone right aims at the negated sense code
    sense_code_i[CH_PHONE_R] <= 8'h02;
    reg_wr(IDX_TRIGGER, 32'h0000_0020);
    reg_rd(IDX_TRIGGER, rd);  `CHK(rd[7:4], 4'h2)
    wait_idle(8'hf0);
    reg_rd(IDX_PHONE_R, rd);  `CHK(rd, 32'h0000_00fe)
    reg_rd(IDX_STATUS, rd);   `CHK(rd[11:0], 12'hb92)

    // Status ignores writes
    reg_wr(IDX_STATUS, 32'h0000_0fff);
    reg_rd(IDX_STATUS, rd);   `CHK(rd, 32'h0000_0b92)

    // Restarting a mode clears its done bit until it completes again
    // Applied code is read before the trigger so no step tick can race the check
    reg_wr(IDX_PHONE_L, 32'h0000_0001);
    reg_rd(IDX_PHONE_L, rd);  `CHK(rd, 32'h0000_0003)
    reg_wr(IDX_TRIGGER, 32'h0000_0001);
    reg_rd(IDX_STATUS, rd);   `CHK(rd[11:0], 12'ha82)
    wait_idle(8'h01);
    reg_rd(IDX_PHONE_L, rd);  `CHK(rd, 32'h0000_0001)
    reg_rd(IDX_STATUS, rd);   `CHK(rd[11:0], 12'hb92)

    // A second reset clears everything again
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    reg_rd(IDX_STATUS, rd);   `CHK(rd, 32'h0000_0000)
    reg_rd(IDX_LINE_R, rd);   `CHK(rd, 32'h0000_0000)
    `CHK(applied_code_o[CH_PHONE_R], RST_OFFSET)

    stop_test();
  end

endmodule

`default_nettype wire
